//--- dmm_pkg.sv
/*
 data memory map package: op codes, targets, addresses, reset values.
 assumes one clock domain and a core that issues one access at a time.
*/
package dmm_pkg;

	typedef enum logic [3:0]
	{
		DMM_OP_DIRECT,
		DMM_OP_INDIRECT,
		DMM_OP_BIT,
		DMM_OP_PUSH,
		DMM_OP_POP,
		DMM_OP_XMOVE8,
		DMM_OP_XMOVE16,
		DMM_OP_CODE_READ,
		DMM_OP_FETCH
	} dmm_op_e;

	typedef enum logic [2:0]
	{
		DMM_T_IRAM,
		DMM_T_SFR,
		DMM_T_SP,
		DMM_T_PAGE,
		DMM_T_EXTERNAL_DATA_RAM,
		DMM_T_USB,
		DMM_T_FLASH,
		DMM_T_CODE
	} dmm_tgt_e;

	localparam logic [7:0]  DMM_SP_ADDR        = 8'h81;
	localparam logic [7:0]  DMM_PAGE_ADDR      = 8'he7;
	localparam logic [7:0]  DMM_UPPER_START    = 8'h80;
	localparam logic [7:0]  DMM_BIT_BYTE_BASE  = 8'h20;
	localparam logic [7:0]  DMM_BIT_SFR_START  = 8'h80;
	localparam logic [7:0]  DMM_SP_RESET       = 8'h07;
	localparam logic [2:0]  DMM_PAGE_RESET     = 3'h0;
	localparam int          DMM_PAGE_LSB       = 0;
	localparam int          DMM_PAGE_WIDTH     = 3;
	localparam int          DMM_IRAM_BYTES     = 256;
	localparam int          DMM_EXTERNAL_DATA_RAM_BYTES     = 1024;
	localparam int          DMM_USB_BYTES      = 1024;
	localparam int          DMM_EXTERNAL_DATA_RAM_REGION_B  = 10;
	localparam int          DMM_BANK_BYTES     = 8;

endpackage

//--- dmm_ram.sv
/*
 single-port byte ram with registered read data, no reset of contents.
 assumes one access per cycle from the address map controller.
*/
`timescale 1ns/10ps
module dmm_ram
#(
	parameter int DEPTH = 256,
	parameter int AW    = 8
)
(
	// clock
	input  wire logic          ref_clk,
	// access
	input  wire logic          en,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output      logic [7:0]    rdata
);

	logic [7:0] mem [DEPTH];

	// refuse a depth that the address cannot cover exactly
	if (DEPTH != (1 << AW))
	begin : g_bad_depth
		$error("dmm_ram depth must equal 2**AW");
	end

	// contents survive reset
	always_ff @(posedge ref_clk)
	begin
		if (en && we)
			mem[addr] <= wdata;
		if (en && !we)
			rdata <= mem[addr];
	end

endmodule // dmm_ram

//--- dmm_map.sv
/*
 data memory address map: internal ram, sfr routing, stack, bit space,
 external ram regions, page select and code space routing.
 assumes the core holds req until done, and that sfr, usb fifo and
 code ports answer reads on the cycle after their strobe.
*/
`timescale 1ns/10ps
module dmm_map
	import dmm_pkg::*;
(
	// clock and reset
	input  wire logic           ref_clk,
	input  wire logic           rst_n,
	// core access
	input  wire logic           req,
	input  wire dmm_pkg::dmm_op_e op,
	input  wire logic           we,
	input  wire logic [15:0]    addr,
	input  wire logic           ptr_sel,
	input  wire logic [7:0]     wdata,
	input  wire logic           bit_wval,
	output      logic           done,
	output      logic [7:0]     rdata,
	// program status word bank bits and flash mode
	input  wire logic           bank_select_low,
	input  wire logic           bank_select_high,
	input  wire logic           flash_write_en,
	// state
	output      logic [7:0]     stack_pointer,
	output      logic [7:0]     external_data_ram_page_select_reg,
	// sfr space
	output      logic           sfr_req,
	output      logic           sfr_we,
	output      logic [7:0]     sfr_addr,
	output      logic [7:0]     sfr_wdata,
	input  wire logic [7:0]     sfr_rdata,
	// usb fifo region
	output      logic           usb_req,
	output      logic           usb_we,
	output      logic [9:0]     usb_addr,
	output      logic [7:0]     usb_wdata,
	input  wire logic [7:0]     usb_rdata,
	// flash write and code reads
	output      logic           flash_wr_req,
	output      logic           code_rd_req,
	output      logic [15:0]    code_addr,
	output      logic [7:0]     code_wdata,
	input  wire logic [7:0]     code_rdata
);

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_PTR,
		ST_ISSUE,
		ST_WAIT,
		ST_WBACK,
		ST_DONE
	} dmm_state_e;

	dmm_state_e  state;
	dmm_op_e     cur_op;
	logic        cur_we;
	logic [15:0] cur_addr;
	logic [7:0]  cur_wdata;
	logic [2:0]  bit_idx;
	logic        cur_bval;
	logic [2:0]  page;
	logic [7:0]  local_rd;
	logic [7:0]  byte_rd;
	logic [7:0]  iram_rdata;
	logic [7:0]  external_data_ram_rdata;

	// direct byte decode, shared by byte and bit operands
	function automatic dmm_tgt_e direct_tgt(input logic [7:0] a);
		if (a < DMM_UPPER_START)
			return DMM_T_IRAM;
		else if (a == DMM_SP_ADDR)
			return DMM_T_SP;
		else if (a == DMM_PAGE_ADDR)
			return DMM_T_PAGE;
		else
			return DMM_T_SFR;
	endfunction

	// bit address to byte address
	function automatic logic [7:0] bit_byte(input logic [7:0] b);
		if (b < DMM_BIT_SFR_START)
			return DMM_BIT_BYTE_BASE + {4'h0, b[6:3]};
		else
			return {b[7:3], 3'h0};
	endfunction

	wire logic [1:0]  bank     = {bank_select_high, bank_select_low};
	wire logic [7:0]  ptr_addr = {3'h0, bank, 2'h0, ptr_sel};
	wire logic        need_ptr = (op == DMM_OP_INDIRECT) || (op == DMM_OP_XMOVE8);
	wire logic [7:0]  sp_inc   = stack_pointer + 8'h01;
	wire logic [7:0]  sp_dec   = stack_pointer - 8'h01;
	wire logic        is_xmove = (cur_op == DMM_OP_XMOVE8) || (cur_op == DMM_OP_XMOVE16);
	wire logic        is_bit   = (cur_op == DMM_OP_BIT);
	wire logic        is_push  = (cur_op == DMM_OP_PUSH);
	wire logic        is_pop   = (cur_op == DMM_OP_POP);
	wire logic        is_code  = (cur_op == DMM_OP_CODE_READ) || (cur_op == DMM_OP_FETCH);

	// target of the latched access
	dmm_tgt_e tgt;
	always_comb
	begin
		tgt = DMM_T_IRAM;
		if (is_code)
			tgt = DMM_T_CODE;
		else if (is_xmove && cur_we && flash_write_en)
			tgt = DMM_T_FLASH;
		else if (is_xmove)
			tgt = cur_addr[DMM_EXTERNAL_DATA_RAM_REGION_B] ? DMM_T_USB : DMM_T_EXTERNAL_DATA_RAM;
		else if ((cur_op == DMM_OP_DIRECT) || is_bit)
			tgt = direct_tgt(cur_addr[7:0]);
		else
			tgt = DMM_T_IRAM;
	end

	// byte addresses and data
	wire logic [7:0]  eff_iaddr = is_push ? sp_inc : cur_addr[7:0];
	wire logic [7:0]  bit_mask  = 8'h01 << bit_idx;
	wire logic [7:0]  bit_merge = cur_bval ? (byte_rd | bit_mask) : (byte_rd & ~bit_mask);
	wire logic        wback     = (state == ST_WBACK);
	wire logic        issue     = (state == ST_ISSUE);
	wire logic        wr_op     = is_push || (cur_we && !is_pop && !is_code);
	wire logic        issue_wr  = issue && wr_op && !is_bit;
	wire logic        strobe    = issue || wback;
	wire logic        strobe_we = issue_wr || wback;
	wire logic [7:0]  out_byte  = wback ? bit_merge : cur_wdata;

	// internal ram port, pointer reads come first from idle
	wire logic        ptr_rd    = (state == ST_IDLE) && req && need_ptr;
	wire logic        iram_en   = ptr_rd || (strobe && tgt == DMM_T_IRAM);
	wire logic        iram_we   = !ptr_rd && strobe_we;
	wire logic [7:0]  iram_addr = ptr_rd ? ptr_addr : eff_iaddr;

	dmm_ram
	#(
		.DEPTH (DMM_IRAM_BYTES),
		.AW    (8)
	)
	u_iram
	(
		.ref_clk (ref_clk),
		.en      (iram_en),
		.we      (iram_we),
		.addr    (iram_addr),
		.wdata   (out_byte),
		.rdata   (iram_rdata)
	);

	dmm_ram
	#(
		.DEPTH (DMM_EXTERNAL_DATA_RAM_BYTES),
		.AW    (DMM_EXTERNAL_DATA_RAM_REGION_B)
	)
	u_external_data_ram
	(
		.ref_clk (ref_clk),
		.en      (strobe && tgt == DMM_T_EXTERNAL_DATA_RAM),
		.we      (strobe_we),
		.addr    (cur_addr[DMM_EXTERNAL_DATA_RAM_REGION_B-1:0]),
		.wdata   (out_byte),
		.rdata   (external_data_ram_rdata)
	);

	// outward strobes
	assign sfr_req      = strobe && tgt == DMM_T_SFR;
	assign sfr_we       = strobe_we;
	assign sfr_addr     = cur_addr[7:0];
	assign sfr_wdata    = out_byte;
	assign usb_req      = strobe && tgt == DMM_T_USB;
	assign usb_we       = strobe_we;
	assign usb_addr     = cur_addr[DMM_EXTERNAL_DATA_RAM_REGION_B-1:0];
	assign usb_wdata    = out_byte;
	assign flash_wr_req = issue_wr && tgt == DMM_T_FLASH;
	assign code_rd_req  = issue && tgt == DMM_T_CODE;
	assign code_addr    = cur_addr;
	assign code_wdata   = cur_wdata;
	assign done         = (state == ST_DONE);
	assign external_data_ram_page_select_reg = {5'h00, page};

	// read data of the issued access
	always_comb
	begin
		unique case (tgt)
			DMM_T_IRAM:  byte_rd = iram_rdata;
			DMM_T_SFR:   byte_rd = sfr_rdata;
			DMM_T_EXTERNAL_DATA_RAM:  byte_rd = external_data_ram_rdata;
			DMM_T_USB:   byte_rd = usb_rdata;
			DMM_T_CODE:  byte_rd = code_rdata;
			DMM_T_FLASH: byte_rd = 8'h00;
			DMM_T_SP,
			DMM_T_PAGE:  byte_rd = local_rd;
		endcase
	end

	// sequencer
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state         <= ST_IDLE;
			stack_pointer <= DMM_SP_RESET;
			page          <= DMM_PAGE_RESET;
			cur_op        <= DMM_OP_DIRECT;
			cur_we        <= 1'b0;
			cur_addr      <= 16'h0000;
			cur_wdata     <= 8'h00;
			bit_idx       <= 3'h0;
			cur_bval      <= 1'b0;
			local_rd      <= 8'h00;
			rdata         <= 8'h00;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (req)
					begin
						cur_op    <= op;
						cur_we    <= we;
						cur_wdata <= wdata;
						cur_bval  <= bit_wval;
						bit_idx   <= addr[2:0];
						cur_addr  <= (op == DMM_OP_BIT) ? {8'h00, bit_byte(addr[7:0])}
							: (op == DMM_OP_POP) ? {8'h00, stack_pointer} : addr;
						state     <= need_ptr ? ST_PTR : ST_ISSUE;
					end
				end
				ST_PTR:
				begin
					if (cur_op == DMM_OP_XMOVE8)
						cur_addr <= {5'h00, page, iram_rdata};
					else
						cur_addr <= {8'h00, iram_rdata};
					state <= ST_ISSUE;
				end
				ST_ISSUE:
				begin
					if (is_push)
						stack_pointer <= sp_inc;
					else if (is_pop)
						stack_pointer <= sp_dec;
					else if (tgt == DMM_T_SP && cur_we && !is_bit)
						stack_pointer <= cur_wdata;
					if (tgt == DMM_T_PAGE && cur_we && !is_bit)
						page <= cur_wdata[DMM_PAGE_LSB +: DMM_PAGE_WIDTH];
					local_rd <= (tgt == DMM_T_SP) ? stack_pointer : {5'h00, page};
					state <= issue_wr ? ST_DONE : ST_WAIT;
				end
				ST_WAIT:
				begin
					rdata <= is_bit ? {7'h00, byte_rd[bit_idx]} : byte_rd;
					state <= (is_bit && cur_we) ? ST_WBACK : ST_DONE;
				end
				ST_WBACK:
				begin
					if (tgt == DMM_T_SP)
						stack_pointer <= bit_merge;
					if (tgt == DMM_T_PAGE)
						page <= bit_merge[DMM_PAGE_LSB +: DMM_PAGE_WIDTH];
					state <= ST_DONE;
				end
				ST_DONE:
					state <= ST_IDLE;
			endcase
		end
	end

endmodule // dmm_map

//--- dmm_map_properties.sv
/*
 checker for dmm_map: reset values, routing, stack and outward strobes.
 assumes the core raises req afresh for every access and holds it to done.
*/
`timescale 1ns/10ps
module dmm_map_chk
	import dmm_pkg::*;
(
	// clock and reset
	input wire logic            ref_clk,
	input wire logic            rst_n,
	// core side
	input wire logic            req, we, flash_write_en, done,
	input wire dmm_pkg::dmm_op_e op,
	input wire logic [15:0]     addr,
	input wire logic [7:0]      stack_pointer, external_data_ram_page_select_reg,
	// far side
	input wire logic            sfr_req, usb_req, flash_wr_req, code_rd_req,
	input wire logic [7:0]      sfr_addr,
	input wire logic [9:0]      usb_addr,
	input wire logic [15:0]     code_addr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic req_q;
	always_ff @(posedge ref_clk)
		req_q <= req;
	wire go = req && !req_q;
	wire xm = go && op == DMM_OP_XMOVE16;
	wire fw = we && flash_write_en;

	AST_SP_RST: assert property ($rose(rst_n) |-> stack_pointer == 8'h07)
		else $error("stack pointer reset value wrong");
	AST_PAGE_RST: assert property ($rose(rst_n) |-> external_data_ram_page_select_reg == 8'h00)
		else $error("page register reset value wrong");
	AST_PAGE_HI: assert property (external_data_ram_page_select_reg[7:3] == 5'h00)
		else $error("page register upper bits not zero");
	AST_PUSH: assert property (go && op == DMM_OP_PUSH
		|-> ##2 done && stack_pointer == $past(stack_pointer, 2) + 8'h01)
		else $error("push did not step stack pointer");
	AST_SFR: assert property (go && op == DMM_OP_DIRECT && addr[7] && addr[7:0] != 8'h81
		&& addr[7:0] != 8'he7 |-> ##[1:3] sfr_req && sfr_addr == addr[7:0])
		else $error("direct upper access not sent to sfr");
	AST_IND: assert property (go && op == DMM_OP_INDIRECT |-> !sfr_req [*5])
		else $error("indirect access reached sfr");
	AST_USB: assert property (xm && addr[10] && !fw
		|-> ##[1:3] usb_req && usb_addr == addr[9:0])
		else $error("usb region access missing");
	AST_EXTERNAL_DATA_RAM: assert property (xm && !addr[10] |-> !usb_req [*4])
		else $error("system ram access reached usb");
	AST_FLASH: assert property (xm && fw |-> ##[1:3] flash_wr_req && code_addr == addr)
		else $error("flash write missing");
	AST_FETCH: assert property (go && op == DMM_OP_FETCH
		|-> ##[1:3] code_rd_req && code_addr == addr)
		else $error("fetch not sent to code space");
endmodule // dmm_map_chk

bind dmm_map dmm_map_chk u_chk (.*);

//--- dmm_far.sv
/*
 far side of dmm_map: sfr, usb fifo ram and code memory responders.
 assumes one-cycle strobes and read data taken on the next cycle.
*/
`timescale 1ns/10ps
module dmm_far
(
	// clock
	input wire logic        ref_clk,
	// strobes
	input wire logic        sfr_req, sfr_we, usb_req, usb_we, code_rd_req, flash_wr_req,
	input wire logic [7:0]  sfr_addr, sfr_wdata, usb_wdata, code_wdata,
	input wire logic [9:0]  usb_addr,
	input wire logic [15:0] code_addr,
	// read data
	output logic [7:0]      sfr_rdata = 8'h00,
	output logic [7:0]      usb_rdata = 8'h00,
	output logic [7:0]      code_rdata = 8'h00
);
	logic [7:0]  sfr_mem [128];
	logic [7:0]  usb_mem [1024];
	logic [7:0]  fl_data = 8'h00;
	logic [15:0] fl_addr = 16'h0000;
	logic        fl_valid = 1'b0;
	wire         fl_hit = fl_valid && fl_addr == code_addr;
	// idle cycles show the inverse of the last value
	always_ff @(posedge ref_clk)
	begin
		sfr_rdata <= sfr_req ? sfr_mem[sfr_addr[6:0]] : ~sfr_rdata;
		usb_rdata <= usb_req ? usb_mem[usb_addr] : ~usb_rdata;
		code_rdata <= code_rd_req ? (fl_hit ? fl_data : code_addr[7:0] ^ code_addr[15:8])
			: ~code_rdata;
		if (sfr_req && sfr_we)
			sfr_mem[sfr_addr[6:0]] <= sfr_wdata;
		if (usb_req && usb_we)
			usb_mem[usb_addr] <= usb_wdata;
		if (flash_wr_req)
		begin
			fl_valid <= 1'b1;
			fl_addr <= code_addr;
			fl_data <= code_wdata;
		end
	end
endmodule // dmm_far

//--- tb.sv
/*
 bench for dmm_map: ram routing, banks, bits, stack, external_data_ram, page and code.
 assumes dmm_far answers the outward strobes.
*/
`timescale 1ns/10ps
module tb;
	import dmm_pkg::*;
	logic ref_clk = 0, rst_n = 0, req = 0, we = 0, ptr_sel = 0, bit_wval = 0;
	logic bank_select_low = 0, bank_select_high = 0, flash_write_en = 0;
	logic done, sfr_req, sfr_we, usb_req, usb_we, flash_wr_req, code_rd_req;
	logic [7:0] wdata = 0, rdata, stack_pointer, external_data_ram_page_select_reg, sfr_addr;
	logic [7:0] sfr_wdata, sfr_rdata, usb_wdata, usb_rdata, code_wdata, code_rdata, d, p;
	logic [15:0] addr = 0, code_addr, a;
	logic [9:0] usb_addr;
	logic [1:0] b;
	dmm_op_e op = DMM_OP_DIRECT;
	int n_errors = 0, comparisons = 0;
	dmm_map dut (.*);
	dmm_far far (.*);
	initial
		forever #25 ref_clk = ~ref_clk;

	function automatic logic [7:0] cexp(input logic [15:0] x);
		return x[15:8] ^ x[7:0];
	endfunction
	task automatic results;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic acc(input dmm_op_e o, input logic w, input logic [15:0] x,
		input logic [7:0] v = 8'h00, input logic s = 1'b0);
		int i;
		op <= o;
		we <= w;
		addr <= x;
		wdata <= v;
		ptr_sel <= s;
		req <= 1'b1;
		i = 0;
		do
		begin
			@(posedge ref_clk);
			i++;
		end
		while (done !== 1'b1 && i < 20);
		req <= 1'b0;
		@(posedge ref_clk);
		if (i >= 20)
		begin
			n_errors++;
			results();
		end
	endtask

	initial
	begin
		d = 8'($urandom(32'hf6fc169c));
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk(stack_pointer, 8'h07);
		chk(external_data_ram_page_select_reg, 8'h00);
		acc(DMM_OP_DIRECT, 0, 16'h0081);
		chk(rdata, 8'h07);
		repeat (4)
		begin
			b = 2'($urandom);
			d = 8'($urandom);
			p = 8'h30 + 8'($urandom % 48);
			bank_select_low <= b[0];
			bank_select_high <= b[1];
			acc(DMM_OP_DIRECT, 1, {11'h0, b, 3'h1}, p);
			acc(DMM_OP_DIRECT, 1, {8'h0, p}, d);
			acc(DMM_OP_INDIRECT, 0, 0, 0, 1);
			chk(rdata, d);
			acc(DMM_OP_DIRECT, 1, {11'h0, b, 3'h0}, p | 8'h80);
			acc(DMM_OP_INDIRECT, 1, 0, ~d, 0);
			acc(DMM_OP_DIRECT, 1, {8'h0, p | 8'h80}, d);
			acc(DMM_OP_INDIRECT, 0, 0);
			chk(rdata, ~d);
			acc(DMM_OP_DIRECT, 0, {8'h0, p | 8'h80});
			chk(rdata, d);
		end
		acc(DMM_OP_DIRECT, 1, 16'h0022, 8'h00);
		bit_wval <= 1'b1;
		acc(DMM_OP_BIT, 1, 16'h0013);
		acc(DMM_OP_DIRECT, 0, 16'h0022);
		chk(rdata, 8'h08);
		acc(DMM_OP_BIT, 0, 16'h0013);
		chk(rdata, 8'h01);
		acc(DMM_OP_PUSH, 1, 0, 8'h5c);
		acc(DMM_OP_PUSH, 1, 0, 8'ha3);
		chk(stack_pointer, 8'h09);
		acc(DMM_OP_POP, 0, 0);
		chk(rdata, 8'ha3);
		chk(stack_pointer, 8'h08);
		acc(DMM_OP_DIRECT, 1, 16'h0081, 8'h40);
		acc(DMM_OP_PUSH, 0, 0, d ^ 8'h5a);
		acc(DMM_OP_DIRECT, 0, 16'h0041);
		chk(rdata, d ^ 8'h5a);
		chk(stack_pointer, 8'h41);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk(stack_pointer, 8'h07);
		acc(DMM_OP_DIRECT, 0, 16'h0008);
		chk(rdata, 8'h5c);
		for (int k = 0; k < 4; k++)
		begin
			a = 16'($urandom);
			a[10] = k[0];
			p = 8'($urandom);
			acc(DMM_OP_XMOVE16, 1, a, p);
			acc(DMM_OP_XMOVE16, 0, a ^ 16'hf800);
			chk(rdata, p);
		end
		flash_write_en <= 1'b1;
		acc(DMM_OP_XMOVE16, 1, a, ~p);
		flash_write_en <= 1'b0;
		acc(DMM_OP_XMOVE16, 0, a);
		chk(rdata, p);
		acc(DMM_OP_CODE_READ, 0, a);
		chk(rdata, ~p);
		acc(DMM_OP_DIRECT, 1, 16'h00e7, 8'h05);
		chk(external_data_ram_page_select_reg, 8'h05);
		acc(DMM_OP_DIRECT, 1, {11'h0, b, 3'h1}, 8'h34);
		acc(DMM_OP_XMOVE8, 1, 0, 8'h9e, 1);
		acc(DMM_OP_XMOVE16, 0, 16'h0534);
		chk(rdata, 8'h9e);
		acc(DMM_OP_CODE_READ, 0, a ^ 16'h00ff);
		chk(rdata, cexp(a ^ 16'h00ff));
		acc(DMM_OP_FETCH, 0, a ^ 16'hff00);
		chk(rdata, cexp(a ^ 16'hff00));
		results();
	end
endmodule // tb
